// >>> rta_host.sv
// Host model that drives the serial clock and data pins of the register block
`timescale 1ns/1ps
module rta_host (
  input wire logic i_clk_sys,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  // Clock starts driven high and data starts released, so the pull-up holds data high
  initial
  begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  // One pin step of 8 clocks keeps each clock phase above 4 clocks
  task automatic step(input logic c, input logic lo, output logic s);
    repeat (8) @(posedge i_clk_sys);
    s = i_sda;
    o_scl <= c;
    o_sda_oe <= lo;
  endtask
  // Start or repeated start: data falls while the clock is high
  task automatic start();
    logic s;
    step(1'b0, 1'b0, s);
    step(1'b1, 1'b0, s);
    step(1'b1, 1'b1, s);
    step(1'b0, 1'b1, s);
  endtask
  // Stop: data rises while the clock is high
  task automatic stop();
    logic s;
    step(1'b0, 1'b1, s);
    step(1'b1, 1'b1, s);
    step(1'b1, 1'b0, s);
  endtask
  // Nine bits out and in; a 1 releases the line, bit 0 is the acknowledge
  task automatic xb(input logic [8:0] d, output logic [8:0] q);
    logic s;
    for (int i = 8; i >= 0; i--)
    begin
      step(1'b0, ~d[i], s);
      step(1'b1, ~d[i], s);
      step(1'b0, ~d[i], q[i]);
    end
  endtask
endmodule

// >>> rta_pkg.sv
// Shared constants and types for the time and alarm register block
package rta_pkg;

  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int RTA_CLK_HZ = 40_000_000;
  localparam int RTA_TICK_HZ = 100;
  localparam int RTA_TICK_CYC = RTA_CLK_HZ / RTA_TICK_HZ;

  // --------------------------------------------------------------------
  // Target address and register offsets
  // --------------------------------------------------------------------
  localparam logic [6:0] RTA_I2C_ADDR = 7'h51;
  localparam int RTA_NREG = 48;
  localparam logic [5:0] RTA_A_HUND = 6'h00;
  localparam logic [5:0] RTA_A_SEC = 6'h01;
  localparam logic [5:0] RTA_A_MIN = 6'h02;
  localparam logic [5:0] RTA_A_HOUR = 6'h03;
  localparam logic [5:0] RTA_A_DAY = 6'h04;
  localparam logic [5:0] RTA_A_WDAY = 6'h05;
  localparam logic [5:0] RTA_A_MON = 6'h06;
  localparam logic [5:0] RTA_A_YEAR = 6'h07;
  localparam logic [5:0] RTA_A_A1_SEC = 6'h08;
  localparam logic [5:0] RTA_A_A1_MIN = 6'h09;
  localparam logic [5:0] RTA_A_A1_HOUR = 6'h0a;
  localparam logic [5:0] RTA_A_A1_DAY = 6'h0b;
  localparam logic [5:0] RTA_A_A1_MON = 6'h0c;
  localparam logic [5:0] RTA_A_A2_MIN = 6'h0d;
  localparam logic [5:0] RTA_A_A2_HOUR = 6'h0e;
  localparam logic [5:0] RTA_A_A2_WDAY = 6'h0f;
  localparam logic [5:0] RTA_A_ALM_EN = 6'h10;
  localparam logic [5:0] RTA_A_OSC = 6'h25;
  localparam logic [5:0] RTA_A_FUNC = 6'h28;
  localparam logic [5:0] RTA_A_INTERRUPT_OUT_FIRST_EN = 6'h29;
  localparam logic [5:0] RTA_A_INTERRUPT_OUT_SECOND_EN = 6'h2a;
  localparam logic [5:0] RTA_A_FLAGS = 6'h2b;
  localparam logic [5:0] RTA_A_RAM = 6'h2c;
  localparam logic [5:0] RTA_A_STOP = 6'h2e;
  localparam logic [5:0] RTA_A_RESETS = 6'h2f;

  // --------------------------------------------------------------------
  // Field positions and command codes
  // --------------------------------------------------------------------
  localparam int RTA_B_OS = 7;
  localparam int RTA_B_EVENT_PENDING_SUMMARY = 7;
  localparam int RTA_B_MERIDIEM_INDICATOR = 5;
  localparam int RTA_B_HR12 = 5;
  localparam int RTA_B_HUND_EN = 7;
  localparam int RTA_B_MODE = 4;
  localparam int RTA_B_A1F = 5;
  localparam int RTA_B_A2F = 6;
  localparam int RTA_B_A1IE = 4;
  localparam int RTA_B_A2IE = 3;
  localparam int RTA_B_STOP = 0;
  localparam logic [7:0] RTA_PRESC_CLR = 8'ha4;

  // --------------------------------------------------------------------
  // Reset values and BCD limits
  // --------------------------------------------------------------------
  localparam logic [7:0] RTA_RST_SEC = 8'h80;
  localparam logic [7:0] RTA_RST_DAY = 8'h01;
  localparam logic [7:0] RTA_RST_WDAY = 8'h06;
  localparam logic [7:0] RTA_RST_MON = 8'h01;
  localparam logic [7:0] RTA_MAX_HUND = 8'h99;
  localparam logic [7:0] RTA_MAX_MS = 8'h59;
  localparam logic [7:0] RTA_MAX_H24 = 8'h23;
  localparam logic [7:0] RTA_MAX_WDAY = 8'h06;
  localparam logic [7:0] RTA_MAX_MON = 8'h12;

  // Target port states
  typedef enum logic [2:0] {
    RTA_IDLE, RTA_ADDR, RTA_AACK, RTA_WDATA, RTA_WACK, RTA_RDATA, RTA_RACK
  } rta_i2c_t;

endpackage

// >>> rta_time_alarm_regs.sv
// Time keeping, alarm registers and serial target port of the calendar clock
`timescale 1ns/1ps

module rta_time_alarm_regs
  import rta_pkg::*;
#(
  parameter int TICK_CYCLES = RTA_TICK_CYC
)
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  output logic o_int_first_n,
  output logic o_int_second_n
);

  localparam int PRE_W = $clog2(TICK_CYCLES);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

  // --------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------
  if (TICK_CYCLES < 2)
  begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  typedef struct packed {
    logic [RTA_NREG-1:0][7:0] regs;
    logic [7:0][7:0] snap;
    logic [PRE_W-1:0] pre;
    rta_i2c_t ist;
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic [5:0] ptr;
    logic rw;
    logic first;
    logic sec_evt;
    logic sda_o;
    logic sda_oe;
    logic int1_n;
    logic int2_n;
  } rta_state_t;

  rta_state_t st_r;
  rta_state_t st_nxt;
  logic tick;
  logic wr_en;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic day_carry;
  logic snap_take;
  logic ptr_adv;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // One BCD step, wrapping to lo once at hi; bit 8 is the carry
  function automatic logic [8:0] bcd_wrap(input logic [7:0] v, input logic [7:0] hi,
                                          input logic [7:0] lo);
    if (v >= hi)
      return {1'b1, lo};
    else if (v[3:0] == 4'h9)
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    else
      return {1'b0, v + 8'h01};
  endfunction

  // Leap years: BCD year divisible by four
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4])
      return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    else
      return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction

  // Last day of the month in BCD
  function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
    case (m[4:0])
      5'h02: return is_leap(y) ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction

  // Hour step in 24 h or 12 h form; carry marks a new day
  function automatic logic [8:0] hour_inc(input logic [7:0] h, input logic h12);
    logic [8:0] s;
    s = bcd_wrap({3'h0, h[4:0]}, 8'h99, 8'h00);
    if (!h12)
      return bcd_wrap({2'h0, h[5:0]}, RTA_MAX_H24, 8'h00);
    else if (h[4:0] == 5'h12)
      return {1'b0, 2'h0, h[RTA_B_MERIDIEM_INDICATOR], 5'h01};
    else if (h[4:0] == 5'h11)
      return {h[RTA_B_MERIDIEM_INDICATOR], 2'h0, ~h[RTA_B_MERIDIEM_INDICATOR], 5'h12};
    else
      return {1'b0, 2'h0, h[RTA_B_MERIDIEM_INDICATOR], s[4:0]};
  endfunction

  // Implemented bits per location; the rest store nothing and read zero, except minutes bit 7, which reads the event summary
  function automatic logic [7:0] reg_mask(input logic [5:0] a, input logic m);
    case (a)
      RTA_A_HUND, RTA_A_SEC: return 8'hff;
      RTA_A_MIN, RTA_A_A1_SEC, RTA_A_A1_MIN, RTA_A_A2_MIN: return 8'h7f;
      RTA_A_HOUR, RTA_A_DAY: return m ? 8'hff : 8'h3f;
      RTA_A_WDAY: return m ? 8'hff : 8'h07;
      RTA_A_MON: return m ? 8'h00 : 8'h1f;
      RTA_A_YEAR: return m ? 8'h00 : 8'hff;
      RTA_A_A1_HOUR, RTA_A_A1_DAY, RTA_A_A2_HOUR: return m ? 8'hff : 8'h3f;
      RTA_A_A1_MON: return m ? 8'hff : 8'h1f;
      RTA_A_A2_WDAY: return m ? 8'hff : 8'h07;
      RTA_A_ALM_EN, RTA_A_OSC, RTA_A_FUNC, RTA_A_INTERRUPT_OUT_FIRST_EN, RTA_A_INTERRUPT_OUT_SECOND_EN, RTA_A_RAM:
        return 8'hff;
      RTA_A_FLAGS: return 8'h60;
      RTA_A_STOP: return 8'h01;
      default: return 8'h00;
    endcase
  endfunction

  // Default time contents of a mode; both modes start with OS set
  function automatic logic [7:0] rst_time(input int i, input logic m);
    case (i)
      1: return RTA_RST_SEC;
      4: return m ? 8'h00 : RTA_RST_DAY;
      5: return m ? 8'h00 : RTA_RST_WDAY;
      6: return m ? 8'h00 : RTA_RST_MON;
      default: return 8'h00;
    endcase
  endfunction

  // Pointer step with wrap past the last location
  function automatic logic [5:0] ptr_inc(input logic [5:0] p);
    return (p >= RTA_A_RESETS) ? 6'h00 : p + 6'h01;
  endfunction

  // Byte returned to the host: time from the snapshot, the rest live
  function automatic logic [7:0] rd_byte(input logic [5:0] a);
    logic [7:0] v;
    logic m;
    m = st_r.regs[RTA_A_FUNC][RTA_B_MODE];
    v = (a < 6'h08) ? st_r.snap[a[2:0]] : st_r.regs[a];
    v = v & reg_mask(a, m);
    if (a == RTA_A_MIN)
      v[RTA_B_EVENT_PENDING_SUMMARY] = |st_r.regs[RTA_A_FLAGS];
    if ((a == RTA_A_HUND) && !st_r.regs[RTA_A_FUNC][RTA_B_HUND_EN])
      v = 8'h00;
    return v;
  endfunction

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  always_comb
  begin
    logic [8:0] c;
    logic [8:0] w;
    logic mode;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [4:0] eq1;
    logic [2:0] eq2;
    logic [4:0] en1;
    logic [2:0] en2;
    logic hit1;
    logic hit2;
    logic [7:0] rb;
    c = 9'h000;
    w = 9'h000;
    rb = 8'h00;
    eq1 = 5'h00;
    eq2 = 3'h0;
    en1 = 5'h00;
    en2 = 3'h0;
    hit1 = 1'b0;
    hit2 = 1'b0;
    st_nxt = st_r;
    tick = 1'b0;
    wr_en = 1'b0;
    wr_addr = st_r.ptr;
    wr_data = st_r.sh;
    day_carry = 1'b0;
    snap_take = 1'b0;
    ptr_adv = 1'b0;
    mode = st_r.regs[RTA_A_FUNC][RTA_B_MODE];
    // Pins pass two stages before any logic looks at them
    st_nxt.scl_q = {st_r.scl_q[1:0], i_scl};
    st_nxt.sda_q = {st_r.sda_q[1:0], i_sda};
    scl_rise = st_r.scl_q[1] & ~st_r.scl_q[2];
    scl_fall = ~st_r.scl_q[1] & st_r.scl_q[2];
    start_c = st_r.scl_q[1] & st_r.scl_q[2] & st_r.sda_q[2] & ~st_r.sda_q[1];
    stop_c = st_r.scl_q[1] & st_r.scl_q[2] & ~st_r.sda_q[2] & st_r.sda_q[1];

    // Prescaler to 100 Hz; frozen while stopped
    if (!st_r.regs[RTA_A_STOP][RTA_B_STOP])
    begin
      if (st_r.pre == PRE_LAST)
      begin
        st_nxt.pre = '0;
        tick = 1'b1;
      end
      else
        st_nxt.pre = st_r.pre + 1'b1;
    end

    // Counter chain; runs regardless of any transfer in progress
    st_nxt.sec_evt = 1'b0;
    if (tick)
    begin
      c = bcd_wrap(st_r.regs[RTA_A_HUND], RTA_MAX_HUND, 8'h00);
      st_nxt.regs[RTA_A_HUND] = c[7:0];
      if (c[8])
      begin
        st_nxt.sec_evt = 1'b1;
        c = bcd_wrap({1'b0, st_r.regs[RTA_A_SEC][6:0]}, RTA_MAX_MS, 8'h00);
        st_nxt.regs[RTA_A_SEC] = {st_r.regs[RTA_A_SEC][RTA_B_OS], c[6:0]};
        if (c[8])
        begin
          c = bcd_wrap({1'b0, st_r.regs[RTA_A_MIN][6:0]}, RTA_MAX_MS, 8'h00);
          st_nxt.regs[RTA_A_MIN] = c[7:0];
          if (c[8] && mode)
          begin
            // Six hour digits in three pairs, lowest first
            c = bcd_wrap(st_r.regs[RTA_A_HOUR], 8'h99, 8'h00);
            st_nxt.regs[RTA_A_HOUR] = c[7:0];
            if (c[8])
            begin
              c = bcd_wrap(st_r.regs[RTA_A_DAY], 8'h99, 8'h00);
              st_nxt.regs[RTA_A_DAY] = c[7:0];
              if (c[8])
              begin
                // Carry bit is dropped on purpose: the top pair simply wraps
                w = bcd_wrap(st_r.regs[RTA_A_WDAY], 8'h99, 8'h00);
                st_nxt.regs[RTA_A_WDAY] = w[7:0];
              end
            end
          end
          else if (c[8])
          begin
            c = hour_inc(st_r.regs[RTA_A_HOUR], st_r.regs[RTA_A_OSC][RTA_B_HR12]);
            st_nxt.regs[RTA_A_HOUR] = c[7:0];
            if (c[8])
            begin
              day_carry = 1'b1;
              w = bcd_wrap(st_r.regs[RTA_A_WDAY], RTA_MAX_WDAY, 8'h00);
              st_nxt.regs[RTA_A_WDAY] = w[7:0];
              c = bcd_wrap(st_r.regs[RTA_A_DAY],
                           last_day(st_r.regs[RTA_A_MON], st_r.regs[RTA_A_YEAR]), 8'h01);
              st_nxt.regs[RTA_A_DAY] = c[7:0];
              if (c[8])
              begin
                c = bcd_wrap(st_r.regs[RTA_A_MON], RTA_MAX_MON, 8'h01);
                st_nxt.regs[RTA_A_MON] = c[7:0];
                if (c[8])
                begin
                  w = bcd_wrap(st_r.regs[RTA_A_YEAR], 8'h99, 8'h00);
                  st_nxt.regs[RTA_A_YEAR] = w[7:0];
                end
              end
            end
          end
        end
      end
    end

    // Serial target: sample on SCL rise, change SDA on SCL fall
    if (start_c)
    begin
      st_nxt.ist = RTA_ADDR;
      st_nxt.bitcnt = 4'h0;
      st_nxt.sda_oe = 1'b0;
    end
    else if (stop_c)
    begin
      st_nxt.ist = RTA_IDLE;
      st_nxt.sda_oe = 1'b0;
    end
    else if (scl_rise)
    begin
      if (st_r.ist == RTA_RACK)
        st_nxt.first = st_r.sda_q[1]; // High means the host ends the read
      else if (st_r.ist != RTA_IDLE)
      begin
        st_nxt.bitcnt = st_r.bitcnt + 4'h1;
        if (st_r.ist != RTA_RDATA)
          st_nxt.sh = {st_r.sh[6:0], st_r.sda_q[1]};
      end
    end
    else if (scl_fall)
    begin
      case (st_r.ist)
        RTA_ADDR:
          if (st_r.bitcnt == 4'h8)
          begin
            if (st_r.sh[7:1] == RTA_I2C_ADDR)
            begin
              st_nxt.ist = RTA_AACK;
              st_nxt.sda_oe = 1'b1;
              st_nxt.rw = st_r.sh[0];
              if (st_r.sh[0])
              begin
                snap_take = 1'b1;
                st_nxt.snap = st_r.regs[7:0];
              end
            end
            else
              st_nxt.ist = RTA_IDLE;
          end
        RTA_AACK, RTA_RACK:
          if (st_r.rw && !(st_r.ist == RTA_RACK && st_r.first))
          begin
            rb = rd_byte(st_r.ptr);
            st_nxt.sh = rb;
            st_nxt.sda_oe = ~rb[7];
            st_nxt.ptr = ptr_inc(st_r.ptr);
            ptr_adv = 1'b1;
            st_nxt.bitcnt = 4'h0;
            st_nxt.ist = RTA_RDATA;
          end
          else if (st_r.rw)
          begin
            st_nxt.sda_oe = 1'b0;
            st_nxt.ist = RTA_IDLE;
          end
          else
          begin
            st_nxt.sda_oe = 1'b0;
            st_nxt.bitcnt = 4'h0;
            st_nxt.first = 1'b1;
            st_nxt.ist = RTA_WDATA;
          end
        RTA_WDATA:
          if (st_r.bitcnt == 4'h8)
          begin
            st_nxt.sda_oe = 1'b1;
            st_nxt.ist = RTA_WACK;
            st_nxt.first = 1'b0;
            if (st_r.first)
              st_nxt.ptr = st_r.sh[5:0];
            else
            begin
              wr_en = 1'b1;
              st_nxt.ptr = ptr_inc(st_r.ptr);
              ptr_adv = 1'b1;
            end
          end
        RTA_WACK:
        begin
          st_nxt.sda_oe = 1'b0;
          st_nxt.bitcnt = 4'h0;
          st_nxt.ist = RTA_WDATA;
        end
        RTA_RDATA:
          if (st_r.bitcnt == 4'h8)
          begin
            st_nxt.sda_oe = 1'b0;
            st_nxt.ist = RTA_RACK;
          end
          else
          begin
            st_nxt.sh = {st_r.sh[6:0], 1'b0};
            st_nxt.sda_oe = ~st_r.sh[6];
          end
        default: st_nxt.ist = RTA_IDLE;
      endcase
    end

    // Host writes override the tick on the same location
    if (wr_en)
    begin
      case (wr_addr)
        RTA_A_RESETS:
          if (wr_data == RTA_PRESC_CLR)
            st_nxt.pre = '0;
        RTA_A_FLAGS:
          st_nxt.regs[RTA_A_FLAGS] = st_r.regs[RTA_A_FLAGS] & wr_data;
        RTA_A_FUNC:
        begin
          st_nxt.regs[RTA_A_FUNC] = wr_data;
          // A mode change restarts the time from that mode's default
          if (wr_data[RTA_B_MODE] != mode)
            for (int i = 0; i < 8; i++)
              st_nxt.regs[i] = rst_time(i, wr_data[RTA_B_MODE]);
        end
        default:
          if (wr_addr < 6'(RTA_NREG))
            st_nxt.regs[wr_addr] = wr_data & reg_mask(wr_addr, mode);
      endcase
    end

    // Alarm compare on the settled time after each seconds step
    eq1[0] = st_r.regs[RTA_A_A1_SEC][6:0] == st_r.regs[RTA_A_SEC][6:0];
    eq1[1] = st_r.regs[RTA_A_A1_MIN][6:0] == st_r.regs[RTA_A_MIN][6:0];
    eq2[0] = st_r.regs[RTA_A_A2_MIN][6:0] == st_r.regs[RTA_A_MIN][6:0];
    if (mode)
    begin
      eq1[2] = st_r.regs[RTA_A_A1_HOUR] == st_r.regs[RTA_A_HOUR];
      eq1[3] = st_r.regs[RTA_A_A1_DAY] == st_r.regs[RTA_A_DAY];
      eq1[4] = st_r.regs[RTA_A_A1_MON] == st_r.regs[RTA_A_WDAY];
      eq2[1] = st_r.regs[RTA_A_A2_HOUR] == st_r.regs[RTA_A_HOUR];
      eq2[2] = st_r.regs[RTA_A_A2_WDAY] == st_r.regs[RTA_A_DAY];
    end
    else
    begin
      eq1[2] = st_r.regs[RTA_A_A1_HOUR][5:0] == st_r.regs[RTA_A_HOUR][5:0];
      eq1[3] = st_r.regs[RTA_A_A1_DAY][5:0] == st_r.regs[RTA_A_DAY][5:0];
      eq1[4] = st_r.regs[RTA_A_A1_MON][4:0] == st_r.regs[RTA_A_MON][4:0];
      eq2[1] = st_r.regs[RTA_A_A2_HOUR][5:0] == st_r.regs[RTA_A_HOUR][5:0];
      eq2[2] = st_r.regs[RTA_A_A2_WDAY][2:0] == st_r.regs[RTA_A_WDAY][2:0];
    end
    en1 = st_r.regs[RTA_A_ALM_EN][4:0];
    en2 = st_r.regs[RTA_A_ALM_EN][7:5];
    hit1 = st_r.sec_evt && (|en1) && ((eq1 | ~en1) == 5'h1f);
    hit2 = st_r.sec_evt && (|en2) && ((eq2 | ~en2) == 3'h7);

    // Flags: a set in the clearing cycle wins
    if (hit1)
      st_nxt.regs[RTA_A_FLAGS][RTA_B_A1F] = 1'b1;
    if (hit2)
      st_nxt.regs[RTA_A_FLAGS][RTA_B_A2F] = 1'b1;

    // Pins follow flag and enable in the same cycle, level style
    st_nxt.int1_n = ~|({st_nxt.regs[RTA_A_FLAGS][RTA_B_A1F],
                        st_nxt.regs[RTA_A_FLAGS][RTA_B_A2F]} &
                       {st_nxt.regs[RTA_A_INTERRUPT_OUT_FIRST_EN][RTA_B_A1IE],
                        st_nxt.regs[RTA_A_INTERRUPT_OUT_FIRST_EN][RTA_B_A2IE]});
    st_nxt.int2_n = ~|({st_nxt.regs[RTA_A_FLAGS][RTA_B_A1F],
                        st_nxt.regs[RTA_A_FLAGS][RTA_B_A2F]} &
                       {st_nxt.regs[RTA_A_INTERRUPT_OUT_SECOND_EN][RTA_B_A1IE],
                        st_nxt.regs[RTA_A_INTERRUPT_OUT_SECOND_EN][RTA_B_A2IE]});
    st_nxt.sda_o = 1'b0; // Open drain: only ever pulls low

    // Reset: calendar mode, 2000-01-01 Saturday 00:00:00.00
    if (i_sys_rst)
    begin
      st_nxt = '0;
      for (int i = 0; i < 8; i++)
        st_nxt.regs[i] = rst_time(i, 1'b0);
      st_nxt.ist = RTA_IDLE;
      st_nxt.int1_n = 1'b1;
      st_nxt.int2_n = 1'b1;
      // Sync stages start at the idle high level so no false edge follows reset
      st_nxt.scl_q = 3'h7;
      st_nxt.sda_q = 3'h7;
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    st_r <= st_nxt;
  end

  assign o_sda_o = st_r.sda_o;
  assign o_sda_oe = st_r.sda_oe;
  assign o_int_first_n = st_r.int1_n;
  assign o_int_second_n = st_r.int2_n;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_stop_no_tick: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    st_r.regs[RTA_A_STOP][RTA_B_STOP] |-> !tick)
    else $error("tick while stopped");
  a_presc_clear: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    wr_en && wr_addr == RTA_A_RESETS && wr_data == RTA_PRESC_CLR |=> st_r.pre == '0)
    else $error("prescaler not cleared");
  a_snap_copy: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    snap_take |=> st_r.snap == $past(st_r.regs[7:0]))
    else $error("snapshot differs from counters");
  a_count_runs: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    tick && !wr_en |=> st_r.regs[RTA_A_HUND] != $past(st_r.regs[RTA_A_HUND]))
    else $error("hundredths did not advance");
  a_flag_sticky: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    st_r.regs[RTA_A_FLAGS][RTA_B_A1F] && !(wr_en && wr_addr == RTA_A_FLAGS)
    |=> st_r.regs[RTA_A_FLAGS][RTA_B_A1F])
    else $error("alarm flag lost");
  a_int_follow: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    ##1 o_int_first_n == !($past(st_r.regs[RTA_A_FLAGS][RTA_B_A1F])
      && $past(st_r.regs[RTA_A_INTERRUPT_OUT_FIRST_EN][RTA_B_A1IE])) || $past(wr_en) || $past(st_r.sec_evt)
      || $past(st_r.regs[RTA_A_FLAGS][RTA_B_A2F]))
    else $error("first interrupt pin mismatch");
  a_ptr_wrap: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    ptr_adv && st_r.ptr == RTA_A_RESETS |=> st_r.ptr == 6'h00)
    else $error("pointer did not wrap");
  a_wday_wrap: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    day_carry && !wr_en && st_r.regs[RTA_A_WDAY] == RTA_MAX_WDAY
    |=> st_r.regs[RTA_A_WDAY] == 8'h00)
    else $error("weekday did not wrap");

endmodule

// >>> rta_time_alarm_regs_tb.sv
// Self-checking testbench of the time and alarm register block
`timescale 1ns/1ps
module rta_time_alarm_regs_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl;
  logic host_oe;
  logic dut_oe;
  logic sda;
  logic int1_n;
  logic int2_n;
  logic sda_val;
  int n_errors = 0;
  int compares = 0;
  always #12.5 clk = ~clk;
  // Open-drain data line with pull-up
  assign sda = ~(dut_oe | host_oe);
  rta_time_alarm_regs #(.TICK_CYCLES(100)) rta_time_alarm_regs_i (.i_clk_sys(clk),
    .i_sys_rst(rst), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_val), .o_sda_oe(dut_oe),
    .o_int_first_n(int1_n), .o_int_second_n(int2_n));
  rta_host rta_host_i (.i_clk_sys(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Whole write transfer from a pointer; every data byte must be acknowledged
  task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
    logic [8:0] q;
    rta_host_i.start();
    rta_host_i.xb({8'ha2, 1'b1}, q);
    rta_host_i.xb({p, 1'b1}, q);
    foreach (d[i])
    begin
      rta_host_i.xb({d[i], 1'b1}, q);
      chk("write ack", 8'h00, {7'h0, q[0]});
    end
    rta_host_i.stop();
  endtask
  // Pointer set, repeated start, then reads; the last byte is not acknowledged
  task automatic rd(input logic [7:0] p, input logic [7:0] e[$]);
    logic [8:0] q;
    rta_host_i.start();
    rta_host_i.xb({8'ha2, 1'b1}, q);
    rta_host_i.xb({p, 1'b1}, q);
    rta_host_i.start();
    rta_host_i.xb({8'ha3, 1'b1}, q);
    foreach (e[i])
    begin
      rta_host_i.xb({8'hff, i == e.size() - 1}, q);
      chk($sformatf("reg %h", p + i), e[i], q[8:1]);
    end
    rta_host_i.stop();
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Tests; expected times follow from a tick every 100 clocks
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, {8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h06, 8'h01, 8'h00});
    $display("test reset values done");
    wr(8'h2e, {8'h01, 8'ha4, 8'h00, 8'h59, 8'h59, 8'h23, 8'h31, 8'h06, 8'h12, 8'h00});
    wr(8'h28, {8'h80});
    rd(8'h00, {8'h00, 8'h59, 8'h59, 8'h23, 8'h31, 8'h06, 8'h12, 8'h00});
    wr(8'h2e, {8'h00});
    repeat (9800) @(posedge clk);
    // Snapshot lands 105 ticks after the resume, so hundredths read 05
    rd(8'h00, {8'h05, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h01});
    $display("test stop load resume done");
    wr(8'h08, {8'h02});
    wr(8'h10, {8'h01});
    wr(8'h29, {8'h10});
    chk("pin first idle", 8'h01, {7'h0, int1_n});
    repeat (20000) @(posedge clk);
    chk("pin first", 8'h00, {7'h0, int1_n});
    chk("pin second", 8'h01, {7'h0, int2_n});
    wr(8'h2a, {8'h10});
    chk("pin second routed", 8'h00, {7'h0, int2_n});
    chk("sda value", 8'h00, {7'h0, sda_val});
    rd(8'h2b, {8'h20});
    wr(8'h2b, {8'h00});
    chk("pin first clear", 8'h01, {7'h0, int1_n});
    chk("pin second clear", 8'h01, {7'h0, int2_n});
    $display("test alarm done");
    wr(8'h28, {8'h10});
    rd(8'h00, {8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    $display("test elapsed mode done");
    summarize();
  end
  // Watchdog well beyond the roughly 50000 clocks the tests need
  initial
  begin
    repeat (90000) @(posedge clk);
    n_errors++;
    summarize();
  end
endmodule
